// >>> hdl/mtp_touch_pattern.sv
// touch limit blocking and multiple touch pattern detection
//
// Contract
// R01: limit disabled: every detected touch reported, nothing blocked.
// R02: limit on (reset 80h): report up to limit, block rest, hold to release.
// R03: after a release, refill reported set in scan order input 1 to 8.
// R04: limit count field bits 3-2: 00 one, 01 two, 10 three, 11 four.
// R05: more touches than limit sets touch_limit_flag while extras are blocked.
// R06: pattern judged only while pattern_detect_enable bit 7 set; resets off.
// R07: level select bits 3-2: 12.5, 25, 37.5 or 100 percent of threshold.
// R08: per-input threshold scaled when active, standby threshold in standby.
// R09: count mode: qualifying inputs at least popcount of mask raises event.
// R10: pattern mode: every masked input must qualify to raise event.
// R11: pattern condition judged on one polling cycle only, no accumulation.
// R12: pattern event blocks all touches while condition persists, then resumes.
// R13: event flag sticky; zero to irq_flag clears once condition gone.
// R14: flag set on every event; interrupt only when pattern_irq_enable set.
// R15: mask bit n-1 selects input n; mask resets to FFh.
// R16: pattern threshold in integer eighths, truncated, no divider.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ns
module mtp_touch_pattern (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [mtp_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [mtp_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [mtp_pkg::DATA_W-1:0] reg_rdata_o,
  // polling results and thresholds
  input wire logic poll_valid_i,
  input wire mtp_pkg::mtp_poll_t poll_i,
  input wire mtp_pkg::mtp_thr_t thr_i,
  // results
  output logic [mtp_pkg::SENSE_N-1:0] touch_report_o,
  output logic touch_limit_flag_o,
  output logic pattern_event_flag_o,
  output logic pattern_active_o,
  output logic irq_n_o
);
  import mtp_pkg::*;

  function automatic logic [3:0] popcount(input logic [SENSE_N-1:0] v);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < SENSE_N; i++) begin
      c = c + {3'h0, v[i]};
    end
    return c;
  endfunction : popcount

  function automatic logic [DELTA_W-1:0] scale_thr(
    input logic [THR_W-1:0] thr,
    input logic [1:0] sel
  );
    logic [3:0] e;
    logic [THR_W+3:0] p;
    case (sel)
      2'h0: e = EIGHTHS_L0;
      2'h1: e = EIGHTHS_L1;
      2'h2: e = EIGHTHS_L2;
      default: e = EIGHTHS_L3;
    endcase
    p = {4'h0, thr} * {{THR_W{1'b0}}, e}; // R16
    return DELTA_W'(p >> EIGHTHS_SHIFT); // R16
  endfunction : scale_thr

  // register state
  logic [7:0] touch_limit_config;
  logic [7:0] pattern_detect_config;
  logic [7:0] pattern_input_mask;
  logic [7:0] event_status;
  logic [7:0] event_mask;
  logic pattern_event_flag;
  logic touch_limit_flag;
  logic pattern_active;
  logic [SENSE_N-1:0] touch_report;
  logic [DATA_W-1:0] rdata;
  logic irq;

  logic [7:0] next_touch_limit_config;
  logic [7:0] next_pattern_detect_config;
  logic [7:0] next_pattern_input_mask;
  logic [7:0] next_event_status;
  logic [7:0] next_event_mask;
  logic next_pattern_event_flag;
  logic next_touch_limit_flag;
  logic next_pattern_active;
  logic [SENSE_N-1:0] next_touch_report;
  logic [DATA_W-1:0] next_rdata;

  // decoded controls
  logic limit_en;
  logic [3:0] limit_n;
  logic pat_en;
  logic pat_mode;
  logic pat_irq_en;
  logic [1:0] pat_level;

  // per-poll evaluation
  logic [SENSE_N-1:0] qualify;
  logic pat_cond;
  logic [SENSE_N-1:0] keep;
  logic [SENSE_N-1:0] pick;
  logic [3:0] taken;
  logic over_limit;
  logic pat_hit;
  logic wr_stat;
  logic wr_ctrl;

  assign limit_en = touch_limit_config[TLC_ENABLE_BIT];
  assign limit_n = {2'h0, touch_limit_config[TLC_COUNT_LSB +: 2]} + 4'h1; // R04
  assign pat_en = pattern_detect_config[PDC_ENABLE_BIT]; // R06
  assign pat_mode = pattern_detect_config[PDC_MODE_BIT];
  assign pat_irq_en = pattern_detect_config[PDC_IRQ_EN_BIT];
  assign pat_level = pattern_detect_config[PDC_LEVEL_LSB +: 2];
  assign wr_stat = reg_wr_i && (reg_addr_i == OFF_EVENT_STATUS);
  assign wr_ctrl = reg_wr_i && (reg_addr_i == OFF_IRQ_CONTROL);
  assign pat_hit = poll_valid_i && pat_en && pat_cond; // R06

  // qualifying inputs and pattern condition for the current poll
  always_comb begin
    logic [THR_W-1:0] base;
    logic [DELTA_W-1:0] lvl;
    base = '0;
    lvl = '0;
    for (int i = 0; i < SENSE_N; i++) begin
      // standby uses the single standby threshold
      base = thr_i.standby ? thr_i.standby_thr
                           : thr_i.touch_thr[i*THR_W +: THR_W]; // R08
      lvl = scale_thr(base, pat_level); // R07
      qualify[i] = (poll_i.delta[i*DELTA_W +: DELTA_W] > lvl) ||
                   poll_i.noise[i];
    end
    if (pat_mode) begin
      // bit n-1 of the mask names input n
      pat_cond = ((qualify & pattern_input_mask) ==
                  pattern_input_mask); // R10 R15
    end else begin
      pat_cond = (popcount(qualify) >=
                  popcount(pattern_input_mask)); // R09 R15
    end
  end

  // touch limit selection in scan order
  always_comb begin
    keep = touch_report & poll_i.touch; // R02
    pick = '0;
    taken = 4'h0;
    // a lowered limit or a report left by the unlimited mode is
    // trimmed here at the next poll, lowest inputs stay, so the limit holds from that poll on
    for (int i = 0; i < SENSE_N; i++) begin
      if (keep[i] && (taken < limit_n)) begin
        pick[i] = 1'b1; // R02
        taken = taken + 4'h1;
      end
    end
    for (int i = 0; i < SENSE_N; i++) begin
      if (poll_i.touch[i] && !pick[i] && (taken < limit_n)) begin
        pick[i] = 1'b1; // R03
        taken = taken + 4'h1;
      end
    end
    over_limit = popcount(poll_i.touch) > limit_n; // R05
  end

  // host configuration registers
  always_comb begin
    next_touch_limit_config = touch_limit_config;
    next_pattern_detect_config = pattern_detect_config;
    next_pattern_input_mask = pattern_input_mask;
    next_event_mask = event_mask;
    if (reg_wr_i) begin
      case (reg_addr_i)
        OFF_TOUCH_LIMIT_CONFIG: begin
          // reserved bits kept zero so readback stays clean
          next_touch_limit_config = reg_wdata_i & TLC_WMASK;
        end
        OFF_PATTERN_DETECT_CONFIG: begin
          next_pattern_detect_config = reg_wdata_i & PDC_WMASK;
        end
        OFF_PATTERN_INPUT_MASK: begin
          next_pattern_input_mask = reg_wdata_i; // R15
        end
        OFF_EVENT_MASK: begin
          next_event_mask = reg_wdata_i & EVT_WMASK;
        end
        default: begin
          // status and control writes act on the flag group
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      touch_limit_config <= RST_TOUCH_LIMIT_CONFIG; // R02
      pattern_detect_config <= RST_PATTERN_DETECT_CONFIG; // R06
      pattern_input_mask <= RST_PATTERN_INPUT_MASK; // R15
      event_mask <= RST_EVENT_MASK;
    end else begin
      touch_limit_config <= next_touch_limit_config;
      pattern_detect_config <= next_pattern_detect_config;
      pattern_input_mask <= next_pattern_input_mask;
      event_mask <= next_event_mask;
    end
  end

  // reported touches and per-poll level flags
  always_comb begin
    next_touch_report = touch_report;
    next_touch_limit_flag = touch_limit_flag;
    next_pattern_active = pattern_active;
    if (poll_valid_i) begin
      // judged on this poll alone, nothing carried over
      next_pattern_active = pat_en && pat_cond; // R06 R11
      if (pat_hit) begin
        // pattern blocking overrides the limit logic
        next_touch_report = '0; // R12
        next_touch_limit_flag = 1'b0;
      end else if (!limit_en) begin
        next_touch_report = poll_i.touch; // R01
        next_touch_limit_flag = 1'b0; // R01
      end else begin
        next_touch_report = pick; // R02 R03
        next_touch_limit_flag = over_limit; // R05
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      touch_report <= '0;
      touch_limit_flag <= 1'b0;
      pattern_active <= 1'b0;
    end else begin
      touch_report <= next_touch_report;
      touch_limit_flag <= next_touch_limit_flag;
      pattern_active <= next_pattern_active;
    end
  end

  // sticky event status and pattern flag
  always_comb begin
    next_event_status = event_status;
    next_pattern_event_flag = pattern_event_flag;
    // write one clears; a same-cycle set below wins
    if (wr_stat) begin
      next_event_status = event_status & ~reg_wdata_i;
    end
    // zero to irq_flag clears only once the condition is gone
    if (wr_ctrl && !reg_wdata_i[IRC_IRQ_FLAG_BIT] && !pattern_active) begin
      next_pattern_event_flag = 1'b0; // R13
    end
    // set on every qualifying poll, not only on the first one
    if (pat_hit) begin
      next_pattern_event_flag = 1'b1; // R14
      next_event_status[EVT_PATTERN_BIT] = 1'b1; // R14
    end
    if (poll_valid_i && !pat_hit && limit_en && over_limit) begin
      next_event_status[EVT_LIMIT_BIT] = 1'b1; // R05
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      event_status <= 8'h00;
      pattern_event_flag <= 1'b0;
    end else begin
      event_status <= next_event_status;
      pattern_event_flag <= next_pattern_event_flag;
    end
  end

  // read data stands for one cycle only, zero otherwise
  always_comb begin
    next_rdata = '0;
    if (reg_rd_i) begin
      case (reg_addr_i)
        OFF_TOUCH_LIMIT_CONFIG: begin
          next_rdata = touch_limit_config;
        end
        OFF_PATTERN_DETECT_CONFIG: begin
          next_rdata = pattern_detect_config;
        end
        OFF_PATTERN_INPUT_MASK: begin
          next_rdata = pattern_input_mask;
        end
        OFF_EVENT_STATUS: begin
          next_rdata = event_status;
        end
        OFF_EVENT_MASK: begin
          next_rdata = event_mask;
        end
        OFF_IRQ_CONTROL: begin
          next_rdata[IRC_IRQ_FLAG_BIT] = irq;
          next_rdata[IRC_PATTERN_FLAG_BIT] = pattern_event_flag;
          next_rdata[IRC_LIMIT_FLAG_BIT] = touch_limit_flag;
          next_rdata[IRC_PATTERN_ACTIVE_BIT] = pattern_active;
        end
        default: begin
          // unmapped reads return zero
          next_rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rdata <= '0;
    end else begin
      rdata <= next_rdata;
    end
  end

  // pattern status always latches; it reaches the pin only if enabled
  assign irq = (event_status[EVT_LIMIT_BIT] & event_mask[EVT_LIMIT_BIT]) |
               (event_status[EVT_PATTERN_BIT] &
                event_mask[EVT_PATTERN_BIT] & pat_irq_en); // R14

  assign irq_n_o = ~irq;
  assign reg_rdata_o = rdata;
  assign touch_report_o = touch_report;
  assign touch_limit_flag_o = touch_limit_flag;
  assign pattern_event_flag_o = pattern_event_flag;
  assign pattern_active_o = pattern_active;
endmodule : mtp_touch_pattern

// >>> hdl/mtp_pkg.sv
// constants and carrier types for the touch limit and pattern detect block
package mtp_pkg;
  localparam int SENSE_N = 8;
  localparam int DELTA_W = 8;
  localparam int THR_W = 7;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [7:0] OFF_TOUCH_LIMIT_CONFIG = 8'h2A;
  localparam logic [7:0] OFF_PATTERN_DETECT_CONFIG = 8'h2B;
  localparam logic [7:0] OFF_PATTERN_INPUT_MASK = 8'h2D;
  localparam logic [7:0] OFF_EVENT_STATUS = 8'h40;
  localparam logic [7:0] OFF_EVENT_MASK = 8'h41;
  localparam logic [7:0] OFF_IRQ_CONTROL = 8'h42;

  // reset values
  localparam logic [7:0] RST_TOUCH_LIMIT_CONFIG = 8'h80;
  localparam logic [7:0] RST_PATTERN_DETECT_CONFIG = 8'h00;
  localparam logic [7:0] RST_PATTERN_INPUT_MASK = 8'hFF;
  localparam logic [7:0] RST_EVENT_MASK = 8'h03;

  // touch_limit_config fields
  localparam int TLC_ENABLE_BIT = 7;
  localparam int TLC_COUNT_LSB = 2;
  localparam logic [7:0] TLC_WMASK = 8'h8C;

  // pattern_detect_config fields
  localparam int PDC_ENABLE_BIT = 7;
  localparam int PDC_LEVEL_LSB = 2;
  localparam int PDC_MODE_BIT = 1;
  localparam int PDC_IRQ_EN_BIT = 0;
  localparam logic [7:0] PDC_WMASK = 8'h8F;

  // event status / mask bits
  localparam int EVT_LIMIT_BIT = 0;
  localparam int EVT_PATTERN_BIT = 1;
  localparam logic [7:0] EVT_WMASK = 8'h03;

  // irq_control bits
  localparam int IRC_IRQ_FLAG_BIT = 0;
  localparam int IRC_PATTERN_FLAG_BIT = 1;
  localparam int IRC_LIMIT_FLAG_BIT = 2;
  localparam int IRC_PATTERN_ACTIVE_BIT = 3;

  // pattern level in eighths of the touch threshold
  localparam logic [3:0] EIGHTHS_L0 = 4'h1;
  localparam logic [3:0] EIGHTHS_L1 = 4'h2;
  localparam logic [3:0] EIGHTHS_L2 = 4'h3;
  localparam logic [3:0] EIGHTHS_L3 = 4'h8;
  localparam int EIGHTHS_SHIFT = 3;

  // results of one polling cycle
  typedef struct packed {
    logic [SENSE_N-1:0] touch;
    logic [SENSE_N-1:0] noise;
    logic [SENSE_N*DELTA_W-1:0] delta;
  } mtp_poll_t;

  // threshold sources for the pattern level
  typedef struct packed {
    logic standby;
    logic [THR_W-1:0] standby_thr;
    logic [SENSE_N*THR_W-1:0] touch_thr;
  } mtp_thr_t;
endpackage : mtp_pkg

// >>> verif/mtp_touch_pattern_checker.sv
// port level assertions for the touch limit and pattern block
`timescale 1ns/1ns
module mtp_touch_pattern_checker (
  // clock, reset and stimulus
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [mtp_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [mtp_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic poll_valid_i,
  input wire mtp_pkg::mtp_poll_t poll_i,
  // watched results
  input wire logic [mtp_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic [mtp_pkg::SENSE_N-1:0] touch_report_o,
  input wire logic touch_limit_flag_o,
  input wire logic pattern_event_flag_o,
  input wire logic pattern_active_o
);
  import mtp_pkg::*;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_rd_idle;
    !$past(reg_rd_i) |-> reg_rdata_o == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
  property p_rep_sub;
    poll_valid_i |=> (touch_report_o & ~$past(poll_i.touch)) == 8'h00;
  endproperty
  a_rep_sub: assert property (p_rep_sub)
    else $error("report holds an untouched input");
  property p_lim_cnt;
    touch_limit_flag_o |-> $countones(touch_report_o) inside {[1:4]};
  endproperty
  a_lim_cnt: assert property (p_lim_cnt)
    else $error("limited report count out of range");
  property p_act_blk;
    pattern_active_o |-> touch_report_o == 8'h00 && !touch_limit_flag_o;
  endproperty
  a_act_blk: assert property (p_act_blk)
    else $error("touches pass during pattern event");
  property p_act_flag;
    pattern_active_o |-> pattern_event_flag_o;
  endproperty
  a_act_flag: assert property (p_act_flag)
    else $error("pattern active without event flag");
  property p_act_rose;
    $rose(pattern_active_o) |-> $past(poll_valid_i);
  endproperty
  a_act_rose: assert property (p_act_rose)
    else $error("pattern condition rose without a poll");
  property p_flag_rose;
    $rose(pattern_event_flag_o) |-> $past(poll_valid_i) && pattern_active_o;
  endproperty
  a_flag_rose: assert property (p_flag_rose)
    else $error("event flag set without a qualifying poll");
  // second reset also clears the flag, so only judge after a live cycle
  property p_flag_fell;
    $fell(pattern_event_flag_o) && $past(rst_n_i) |->
      $past(reg_wr_i && reg_addr_i == OFF_IRQ_CONTROL &&
      !reg_wdata_i[IRC_IRQ_FLAG_BIT] && !pattern_active_o);
  endproperty
  a_flag_fell: assert property (p_flag_fell)
    else $error("event flag cleared without a legal clear");
endmodule : mtp_touch_pattern_checker

bind mtp_touch_pattern mtp_touch_pattern_checker i_chk (.sys_clk_i,
  .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
  .poll_valid_i, .poll_i, .reg_rdata_o, .touch_report_o,
  .touch_limit_flag_o, .pattern_event_flag_o, .pattern_active_o);

// >>> verif/mtp_host_model.sv
// host controller model speaking the register port
`timescale 1ns/1ns
module mtp_host_model (
  // clock
  input wire logic sys_clk_i,
  // register port
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  input wire logic [7:0] reg_rdata_i
);
  initial begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end
  // address and data scrambled when idle so stale values never help
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    #1 d = reg_rdata_i;
  endtask : rd
  task automatic clr_flag();
    wr(8'h42, 8'h00);
  endtask : clr_flag
endmodule : mtp_host_model

// >>> verif/mtp_touch_pattern_test.sv
// self-checking bench for the touch limit and pattern block
`timescale 1ns/1ns
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fails++; \
  $display("unexpected t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module mtp_touch_pattern_test;
  import mtp_pkg::*;
  logic sys_clk_i;
  logic rst_n_i;
  logic [7:0] addr, wdata, rdata, rv, rep;
  logic wr, rd, pv, irq_n, lim_f, evt_f, act;
  mtp_poll_t poll;
  mtp_thr_t thr;
  int fails, checks;
  // limit cfg, pattern cfg, mask, touch, noise, delta, report, flags
  logic [63:0] rows [27] = '{
    64'h8000FF0600000201, 64'h8000FF0600000201, 64'h8000FF0400000400,
    64'h8000FF0500000401, 64'h8400FF0F00000501, 64'h8800FF0F00000701,
    64'h8C00FF0F00000F00, 64'h8C00FFFF00000F01, 64'h0000FFFF0000FF00,
    64'h0000FF0000000000, 64'h0080FF0300090002, 64'h0080FF0300080300,
    64'h00800F0103000100, 64'h00800F010C000100, 64'h00800F010F000002,
    64'h00820F01F0000100, 64'h00820F010F000002, 64'h0082800180000002,
    64'h0084FF0100100100, 64'h0084FF0100110002, 64'h0088FF0100180100,
    64'h0088FF0100190002, 64'h008CFF0100400100, 64'h008CFF0100410002,
    64'h000CFF0100410100, 64'h0084FF0100040110, 64'h0084FF0100050012};
  mtp_host_model i_host (.sys_clk_i, .reg_addr_o(addr),
    .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd), .reg_rdata_i(rdata));
  mtp_touch_pattern i_dut (.sys_clk_i, .rst_n_i, .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .poll_valid_i(pv), .poll_i(poll), .thr_i(thr), .touch_report_o(rep),
    .touch_limit_flag_o(lim_f), .pattern_event_flag_o(evt_f),
    .pattern_active_o(act), .irq_n_o(irq_n));
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  task automatic poll_once(input logic [7:0] t, n, d, input logic sb);
    @(posedge sys_clk_i);
    pv <= 1'b1;
    poll <= '{t, n, {8{d}}};
    thr.standby <= sb;
    @(posedge sys_clk_i);
    pv <= 1'b0;
    poll <= '{~t, ~n, ~{8{d}}};
    #1;
  endtask : poll_once
  task automatic rchk(input logic [7:0] a, e);
    i_host.rd(a, rv);
    `CHK(rv, e)
  endtask : rchk
  task automatic final_report();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (4000) @(posedge sys_clk_i);
    fails++;
    final_report();
  end
  initial begin
    rst_n_i = 1'b0;
    pv = 1'b0;
    poll = '0;
    thr = '{1'b0, 7'h10, {8{7'h40}}};
    fails = 0;
    checks = 0;
    repeat (5) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    rchk(8'h2A, 8'h80);
    rchk(8'h2B, 8'h00);
    rchk(8'h2D, 8'hFF);
    rchk(8'h3F, 8'h00);
    rchk(8'h41, 8'h03);
    i_host.wr(8'h2A, 8'hFF);
    rchk(8'h2A, 8'h8C);
    foreach (rows[i]) begin
      i_host.wr(8'h2A, rows[i][63:56]);
      i_host.wr(8'h2B, rows[i][55:48]);
      i_host.wr(8'h2D, rows[i][47:40]);
      poll_once(rows[i][39:32], rows[i][31:24], rows[i][23:16], rows[i][4]);
      `CHK({rep, act, lim_f}, {rows[i][15:8], rows[i][1:0]})
    end // rows above also
    i_host.wr(8'h40, 8'h03);
    `CHK(irq_n, 1'b1)
    i_host.wr(8'h2B, 8'h80);
    poll_once(8'h00, 8'hFF, 8'h00, 1'b0);
    rchk(8'h40, 8'h02);
    `CHK(irq_n, 1'b1)
    i_host.wr(8'h2B, 8'h81);
    `CHK(irq_n, 1'b0)
    rchk(8'h42, 8'h0B);
    i_host.wr(8'h41, 8'h01);
    `CHK(irq_n, 1'b1)
    i_host.wr(8'h41, 8'h03);
    i_host.clr_flag();
    `CHK(evt_f, 1'b1)
    poll_once(8'h01, 8'h00, 8'h00, 1'b0);
    `CHK({rep, act, evt_f}, {8'h01, 2'b01})
    i_host.clr_flag();
    `CHK(evt_f, 1'b0)
    i_host.wr(8'h40, 8'h02);
    `CHK(irq_n, 1'b1)
    // mid-run reset must bring back the output defaults and the limit and pattern config reset values
    i_host.wr(8'h2A, 8'h00);
    @(posedge sys_clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    `CHK({rep, act, evt_f, lim_f, irq_n}, 12'h001)
    rchk(8'h2A, 8'h80);
    rchk(8'h2B, 8'h00);
    final_report();
  end
endmodule : mtp_touch_pattern_test
